// >>> src/ptp_index_pkg.sv
// Constants for the PTP version, unit index and trigger status registers
package ptp_index_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_TRIG = 3;
  localparam int NUM_TS = 2;
  localparam int VER_W = 4;
  localparam int DOM_W = 8;
  localparam int TRIG_SEL_W = 2;

  // Register byte offsets
  localparam logic [11:0] VERSION_DOMAIN_OFS = 12'h518;
  localparam logic [11:0] UNIT_SELECTOR_OFS = 12'h520;
  localparam logic [11:0] TRIG_STATUS_OFS = 12'h524;
  localparam logic [11:0] MSG_CHECK_CFG_OFS = 12'h5c0;
  localparam logic [11:0] IRQ_ENABLE_OFS = 12'h5c4;
  localparam logic [11:0] IRQ_CLEAR_OFS = 12'h5c8;
  localparam logic [11:0] UNIT_RANGE_LO = 12'h52c;
  localparam logic [11:0] UNIT_RANGE_HI = 12'h5b3;

  // Field positions
  localparam int VER_LSB = 8;
  localparam int DOM_LSB = 0;
  localparam int TS_SEL_BIT = 8;
  localparam int TRIG_SEL_LSB = 0;
  localparam int ERR_LSB = 16;
  localparam int DONE_LSB = 0;
  localparam int DOM_CHECK_BIT = 4;

  // Reset values and codes
  localparam logic [3:0] VER_RST = 4'h2;
  localparam logic [7:0] DOM_RST = 8'h00;
  localparam logic [1:0] TRIG_SEL_RST = 2'h0;
  localparam logic [1:0] TRIG_SEL_RESERVED = 2'h3;
  localparam logic TS_SEL_RST = 1'b0;
  localparam logic DOM_CHECK_RST = 1'b0;
  localparam logic [2:0] STATUS_RST = 3'h0;

  typedef enum logic [0:0] {
    APB_WAIT = 1'b0,
    APB_ANSWER = 1'b1
  } apb_state_t;
endpackage

// >>> src/ptp_filter_if.sv
// Carrier between the register bank and the received message filter
`timescale 1ns/1ps
`default_nettype none
interface ptp_filter_if;
  logic [3:0] expected_version;
  logic [7:0] expected_domain_number;
  logic domain_check_en;
  logic msg_valid;
  logic [3:0] msg_version;
  logic [7:0] msg_domain;
  logic capture;
  logic drop;

  modport cfg (
    output expected_version,
    output expected_domain_number,
    output domain_check_en,
    output msg_valid,
    output msg_version,
    output msg_domain,
    input capture,
    input drop
  );

  modport filt (
    input expected_version,
    input expected_domain_number,
    input domain_check_en,
    input msg_valid,
    input msg_version,
    input msg_domain,
    output capture,
    output drop
  );
endinterface
`default_nettype wire

// >>> src/ptp_msg_filter.sv
// Received PTP message version and domain filter
`timescale 1ns/1ps
`default_nettype none
module ptp_msg_filter (
  input wire logic pclk,
  input wire logic presetn,
  ptp_filter_if.filt f
);
  typedef struct packed {
    logic capture;
    logic drop;
  } filt_state_t;

  filt_state_t st_reg;
  filt_state_t st_next;
  logic ver_ok;
  logic dom_ok;

  always_comb begin
    st_next = st_reg;
    ver_ok = (f.msg_version == f.expected_version);
    dom_ok = !f.domain_check_en || (f.msg_domain == f.expected_domain_number);
    st_next.capture = f.msg_valid && ver_ok && dom_ok;
    st_next.drop = f.msg_valid && !(ver_ok && dom_ok);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign f.capture = st_reg.capture;
  assign f.drop = st_reg.drop;
endmodule
`default_nettype wire

// >>> src/ptp_unit_index_trigger_status.sv
// PTP version/domain, unit index and trigger status register bank on APB
// Operation
// - Hold 4-bit expected version, reset 2; capture messages whose version matches.
// - Drop received PTP messages whose version differs from expected version.
// - Hold 8-bit expected domain; with checking on, capture only matching domains.
// - With domain checking off, ignore the received domain number.
// - Steer unit-range accesses to the selected timestamp and trigger units.
// - 1-bit timestamp unit selector, reset 0, picks unit 0 or 1.
// - 2-bit trigger selector, reset 0, codes 0..2; code 3 never programmed.
// - Late trigger time with notify set raises error bit 16+unit, and interrupt if its enable bit is set.
// - Error flag clears on trigger enable written 0 or on write one.
// - Output generated with notify set raises done bit unit, cleared by write one.
`timescale 1ns/1ps
`default_nettype none
module ptp_unit_index_trigger_status (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ptp_index_pkg::ADDR_W-1:0] paddr,
  input wire logic [ptp_index_pkg::DATA_W-1:0] pwdata,
  output logic [ptp_index_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [ptp_index_pkg::NUM_TRIG-1:0] trigger_irq_request,
  input wire logic [ptp_index_pkg::NUM_TRIG-1:0] trig_done_event,
  input wire logic [ptp_index_pkg::NUM_TRIG-1:0] trig_late_event,
  input wire logic [ptp_index_pkg::NUM_TRIG-1:0] trig_enable_cleared,
  input wire logic rx_msg_valid,
  input wire logic [ptp_index_pkg::VER_W-1:0] rx_msg_version,
  input wire logic [ptp_index_pkg::DOM_W-1:0] rx_msg_domain,
  output logic capture_enable,
  output logic msg_drop,
  output logic timestamp_unit_select,
  output logic [ptp_index_pkg::TRIG_SEL_W-1:0] trigger_unit_select,
  output logic [ptp_index_pkg::NUM_TS-1:0] ts_unit_strobe,
  output logic [ptp_index_pkg::NUM_TRIG-1:0] trig_unit_strobe,
  output logic unit_access_write
);
  typedef struct packed {
    ptp_index_pkg::apb_state_t apb;
    logic [ptp_index_pkg::DATA_W-1:0] rdata;
    logic slverr;
    logic [ptp_index_pkg::VER_W-1:0] version;
    logic [ptp_index_pkg::DOM_W-1:0] domain;
    logic dom_check;
    logic ts_sel;
    logic [ptp_index_pkg::TRIG_SEL_W-1:0] trig_sel;
    logic [ptp_index_pkg::NUM_TRIG-1:0] err;
    logic [ptp_index_pkg::NUM_TRIG-1:0] done;
    logic [ptp_index_pkg::NUM_TRIG-1:0] err_en;
    logic [ptp_index_pkg::NUM_TRIG-1:0] done_en;
    logic irq;
    logic [ptp_index_pkg::NUM_TS-1:0] ts_strobe;
    logic [ptp_index_pkg::NUM_TRIG-1:0] trig_strobe;
    logic unit_wr;
  } bank_state_t;

  bank_state_t st_reg;
  bank_state_t st_next;

  ptp_filter_if fif ();

  assign fif.expected_version = st_reg.version;
  assign fif.expected_domain_number = st_reg.domain;
  assign fif.domain_check_en = st_reg.dom_check;
  assign fif.msg_valid = rx_msg_valid;
  assign fif.msg_version = rx_msg_version;
  assign fif.msg_domain = rx_msg_domain;

  ptp_msg_filter u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .f(fif.filt)
  );

  logic access;
  logic commit;
  logic wr;
  logic aligned;
  logic in_unit_range;
  logic hit_verdom;
  logic hit_unitsel;
  logic hit_status;
  logic hit_cfg;
  logic hit_en;
  logic hit_clr;
  logic mapped;
  logic [ptp_index_pkg::NUM_TRIG-1:0] w1c_err;
  logic [ptp_index_pkg::NUM_TRIG-1:0] w1c_done;
  logic [ptp_index_pkg::NUM_TRIG-1:0] set_err;
  logic [ptp_index_pkg::NUM_TRIG-1:0] set_done;
  logic [ptp_index_pkg::NUM_TRIG-1:0] clr_err;
  logic [ptp_index_pkg::DATA_W-1:0] rd_val;
  logic [ptp_index_pkg::DATA_W-1:0] status_word;
  logic [ptp_index_pkg::DATA_W-1:0] enable_word;
  logic [ptp_index_pkg::TRIG_SEL_W-1:0] new_trig_sel;
  logic [ptp_index_pkg::NUM_TRIG-1:0] trig_pick;
  logic [ptp_index_pkg::NUM_TS-1:0] ts_pick;

  // Per trigger unit event qualifiers and selector decode
  for (genvar u = 0; u < ptp_index_pkg::NUM_TRIG; u++) begin : g_trig
    // late trigger counts only with notify set
    assign set_err[u] = trig_late_event[u] && trigger_irq_request[u];
    // generated output counts only with notify set
    assign set_done[u] = trig_done_event[u] && trigger_irq_request[u];
    assign trig_pick[u] = (32'(st_reg.trig_sel) == u);
  end

  for (genvar s = 0; s < ptp_index_pkg::NUM_TS; s++) begin : g_ts
    assign ts_pick[s] = (32'(st_reg.ts_sel) == s);
  end

  always_comb begin
    st_next = st_reg;
    access = psel && penable;
    // Writes and unit strobes take effect on the edge with pready high; read data is latched one edge earlier
    commit = access && (st_reg.apb == ptp_index_pkg::APB_ANSWER);
    wr = commit && pwrite;
    aligned = (paddr[1:0] == 2'b00);
    in_unit_range = aligned && (paddr >= ptp_index_pkg::UNIT_RANGE_LO)
      && (paddr <= ptp_index_pkg::UNIT_RANGE_HI);
    hit_verdom = (paddr == ptp_index_pkg::VERSION_DOMAIN_OFS);
    hit_unitsel = (paddr == ptp_index_pkg::UNIT_SELECTOR_OFS);
    hit_status = (paddr == ptp_index_pkg::TRIG_STATUS_OFS);
    hit_cfg = (paddr == ptp_index_pkg::MSG_CHECK_CFG_OFS);
    hit_en = (paddr == ptp_index_pkg::IRQ_ENABLE_OFS);
    hit_clr = (paddr == ptp_index_pkg::IRQ_CLEAR_OFS);
    mapped = hit_verdom || hit_unitsel || hit_status || hit_cfg || hit_en || hit_clr
      || in_unit_range;

    // read words with reserved bits zero
    status_word = '0;
    status_word[ptp_index_pkg::ERR_LSB +: ptp_index_pkg::NUM_TRIG] = st_reg.err;
    status_word[ptp_index_pkg::DONE_LSB +: ptp_index_pkg::NUM_TRIG] = st_reg.done;
    enable_word = '0;
    enable_word[ptp_index_pkg::ERR_LSB +: ptp_index_pkg::NUM_TRIG] = st_reg.err_en;
    enable_word[ptp_index_pkg::DONE_LSB +: ptp_index_pkg::NUM_TRIG] = st_reg.done_en;
    rd_val = '0;
    if (hit_verdom) begin
      rd_val[ptp_index_pkg::VER_LSB +: ptp_index_pkg::VER_W] = st_reg.version;
      rd_val[ptp_index_pkg::DOM_LSB +: ptp_index_pkg::DOM_W] = st_reg.domain;
    end else if (hit_unitsel) begin
      rd_val[ptp_index_pkg::TS_SEL_BIT] = st_reg.ts_sel;
      rd_val[ptp_index_pkg::TRIG_SEL_LSB +: ptp_index_pkg::TRIG_SEL_W] = st_reg.trig_sel;
    end else if (hit_status) begin
      rd_val = status_word;
    end else if (hit_cfg) begin
      rd_val[ptp_index_pkg::DOM_CHECK_BIT] = st_reg.dom_check;
    end else if (hit_en) begin
      rd_val = enable_word;
    end

    // APB answer: one wait cycle, then pready from a flop
    unique case (st_reg.apb)
      ptp_index_pkg::APB_WAIT: begin
        if (access) begin
          st_next.apb = ptp_index_pkg::APB_ANSWER;
          st_next.rdata = pwrite ? '0 : rd_val;
          st_next.slverr = !mapped;
        end
      end
      ptp_index_pkg::APB_ANSWER: begin
        st_next.apb = ptp_index_pkg::APB_WAIT;
        st_next.slverr = 1'b0;
      end
    endcase

    // Register writes
    if (wr && hit_verdom) begin
      st_next.version = pwdata[ptp_index_pkg::VER_LSB +: ptp_index_pkg::VER_W];
      st_next.domain = pwdata[ptp_index_pkg::DOM_LSB +: ptp_index_pkg::DOM_W];
    end
    if (wr && hit_cfg) begin
      st_next.dom_check = pwdata[ptp_index_pkg::DOM_CHECK_BIT];
    end
    new_trig_sel = pwdata[ptp_index_pkg::TRIG_SEL_LSB +: ptp_index_pkg::TRIG_SEL_W];
    if (wr && hit_unitsel) begin
      st_next.ts_sel = pwdata[ptp_index_pkg::TS_SEL_BIT];
      // reserved trigger code keeps old value
      if (new_trig_sel != ptp_index_pkg::TRIG_SEL_RESERVED) begin
        st_next.trig_sel = new_trig_sel;
      end
    end
    if (wr && hit_en) begin
      st_next.err_en = pwdata[ptp_index_pkg::ERR_LSB +: ptp_index_pkg::NUM_TRIG];
      st_next.done_en = pwdata[ptp_index_pkg::DONE_LSB +: ptp_index_pkg::NUM_TRIG];
    end

    // Write-one clears from status or clear register
    w1c_err = '0;
    w1c_done = '0;
    if (wr && (hit_status || hit_clr)) begin
      w1c_err = pwdata[ptp_index_pkg::ERR_LSB +: ptp_index_pkg::NUM_TRIG];
      w1c_done = pwdata[ptp_index_pkg::DONE_LSB +: ptp_index_pkg::NUM_TRIG];
    end

    // enable written 0 or write one clears error
    clr_err = w1c_err | trig_enable_cleared;
    // Set wins over clear in the same cycle
    st_next.err = (st_reg.err & ~clr_err) | set_err;
    st_next.done = (st_reg.done & ~w1c_done) | set_done;

    st_next.irq = |((st_next.err & st_next.err_en) | (st_next.done & st_next.done_en));

    // one-hot strobes to the selected units
    st_next.ts_strobe = '0;
    st_next.trig_strobe = '0;
    st_next.unit_wr = 1'b0;
    if (commit && in_unit_range) begin
      st_next.ts_strobe = ts_pick;
      st_next.trig_strobe = trig_pick;
      st_next.unit_wr = pwrite;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.apb <= ptp_index_pkg::APB_WAIT;
      st_reg.rdata <= '0;
      st_reg.slverr <= 1'b0;
      st_reg.version <= ptp_index_pkg::VER_RST;
      st_reg.domain <= ptp_index_pkg::DOM_RST;
      st_reg.dom_check <= ptp_index_pkg::DOM_CHECK_RST;
      st_reg.ts_sel <= ptp_index_pkg::TS_SEL_RST;
      st_reg.trig_sel <= ptp_index_pkg::TRIG_SEL_RST;
      st_reg.err <= ptp_index_pkg::STATUS_RST;
      st_reg.done <= ptp_index_pkg::STATUS_RST;
      st_reg.err_en <= ptp_index_pkg::STATUS_RST;
      st_reg.done_en <= ptp_index_pkg::STATUS_RST;
      st_reg.irq <= 1'b0;
      st_reg.ts_strobe <= '0;
      st_reg.trig_strobe <= '0;
      st_reg.unit_wr <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.rdata;
  assign pready = (st_reg.apb == ptp_index_pkg::APB_ANSWER);
  assign pslverr = st_reg.slverr;
  assign irq = st_reg.irq;
  assign capture_enable = fif.capture;
  assign msg_drop = fif.drop;
  assign timestamp_unit_select = st_reg.ts_sel;
  assign trigger_unit_select = st_reg.trig_sel;
  assign ts_unit_strobe = st_reg.ts_strobe;
  assign trig_unit_strobe = st_reg.trig_strobe;
  assign unit_access_write = st_reg.unit_wr;
endmodule
`default_nettype wire

// >>> tb/ptp_unit_index_trigger_status_checker.sv
// Checker for the PTP index and trigger status register bank
`timescale 1ns/1ps
`default_nettype none
module ptp_unit_index_trigger_status_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic [2:0] trigger_irq_request,
  input wire logic [2:0] trig_done_event,
  input wire logic [2:0] trig_late_event,
  input wire logic rx_msg_valid,
  input wire logic capture_enable,
  input wire logic msg_drop,
  input wire logic timestamp_unit_select,
  input wire logic [1:0] trigger_unit_select,
  input wire logic [1:0] ts_unit_strobe,
  input wire logic [2:0] trig_unit_strobe
);
  logic rng, sel_done, cause;
  logic [2:0] sel_nx;
  assign rng = pready && paddr[1:0] == 2'h0 && paddr >= 12'h52c && paddr <= 12'h5b3;
  assign sel_done = pready && pwrite && !pslverr && paddr == 12'h520;
  assign sel_nx = {pwdata[8], pwdata[1:0] == 2'h3 ? trigger_unit_select : pwdata[1:0]};
  assign cause = |((trig_done_event | trig_late_event) & trigger_irq_request) || (pready && pwrite);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_range_no_err: assert property (rng |-> !pslverr)
    else $error("unit range refused");
  a_ts_strobe_pick: assert property (rng |=> ts_unit_strobe == 2'h1 << $past(timestamp_unit_select))
    else $error("wrong timestamp unit strobe");
  a_trig_strobe_pick: assert property (rng |=> trig_unit_strobe == 3'h1 << $past(trigger_unit_select))
    else $error("wrong trigger unit strobe");
  a_no_stray_strobe: assert property ((|ts_unit_strobe || |trig_unit_strobe) |-> $past(rng))
    else $error("strobe without unit access");
  a_trig_sel_legal: assert property (trigger_unit_select != 2'h3)
    else $error("reserved trigger selector");
  a_sel_write_only: assert property (presetn
    && $changed({timestamp_unit_select, trigger_unit_select})
    |-> $past(sel_done) && {timestamp_unit_select, trigger_unit_select} == $past(sel_nx))
    else $error("selector changed wrongly");
  a_filter_answer: assert property (!(capture_enable && msg_drop)
    && (capture_enable || msg_drop) == $past(rx_msg_valid))
    else $error("filter answer wrong");
  a_irq_has_cause: assert property ($rose(irq) |-> $past(cause) || $past(cause, 2))
    else $error("irq rose without cause");
endmodule
bind ptp_unit_index_trigger_status ptp_unit_index_trigger_status_checker chk (.*);
`default_nettype wire

// >>> tb/ptp_unit_index_trigger_status_bench.sv
// Self-checking bench for the PTP index and trigger status bank
`timescale 1ns/1ps
`default_nettype none
module ptp_unit_index_trigger_status_bench;
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rx_msg_valid = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, capture_enable, msg_drop, timestamp_unit_select, unit_access_write;
  logic [2:0] trigger_irq_request = 3'h0, trig_done_event = 3'h0;
  logic [2:0] trig_late_event = 3'h0, trig_enable_cleared = 3'h0, trig_unit_strobe;
  logic [3:0] rx_msg_version = 4'h0;
  logic [7:0] rx_msg_domain = 8'h00;
  logic [1:0] trigger_unit_select, ts_unit_strobe, rnote, t;
  logic [33:0] bus_q[$], note;
  logic [1:0] rx_q[$];
  logic [5:0] unit_q[$], unote;
  logic chk = 1'b0;
  int errors = 0, n_tests = 0, seed = 64;
  ptp_unit_index_trigger_status uut (.*);
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (bus_q.size() != 0 || rx_q.size() != 0 || unit_q.size() != 0) errors++;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Read notes d as expected data
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    bus_q.push_back({!w, e, d});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic ev(input logic [2:0] dn, input logic [2:0] lt, input logic [2:0] ec,
      input logic [2:0] nt);
    trig_done_event <= dn;
    trig_late_event <= lt;
    trig_enable_cleared <= ec;
    trigger_irq_request <= nt;
    @(posedge pclk);
    trig_done_event <= 3'h0;
    trig_late_event <= 3'h0;
    trig_enable_cleared <= 3'h0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic rx(input logic [3:0] v, input logic [7:0] dm);
    logic c;
    c = v == 4'h5 && (!chk || dm == 8'ha7);
    rx_q.push_back({c, !c});
    rx_msg_valid <= 1'b1;
    rx_msg_version <= v;
    rx_msg_domain <= dm;
    @(posedge pclk);
    rx_msg_valid <= 1'b0;
    @(posedge pclk);
  endtask
  // Result watcher
  always @(posedge pclk) begin
    if (pready === 1'b1 && bus_q.size() > 0) begin
      note = bus_q.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
      if (note[33]) check("prdata", prdata, note[31:0]);
    end
    if ((capture_enable === 1'b1 || msg_drop === 1'b1) && rx_q.size() > 0) begin
      rnote = rx_q.pop_front();
      check("filter", {30'h0, capture_enable, msg_drop}, {30'h0, rnote});
    end
    if ((|ts_unit_strobe === 1'b1 || |trig_unit_strobe === 1'b1) && unit_q.size() > 0) begin
      unote = unit_q.pop_front();
      check("ts strobe", {30'h0, ts_unit_strobe}, {30'h0, unote[4:3]});
      check("trig strobe", {29'h0, trig_unit_strobe}, {29'h0, unote[2:0]});
      check("unit write", {31'h0, unit_access_write}, {31'h0, unote[5]});
    end
  end
  initial begin
    logic [31:0] r;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h518, 32'h200, 1'b0);
    apb(1'b0, 12'h520, 32'h0, 1'b0);
    apb(1'b0, 12'h524, 32'h0, 1'b0);
    apb(1'b1, 12'h518, 32'hffff_f5a7, 1'b0);
    apb(1'b0, 12'h518, 32'h5a7, 1'b0);
    apb(1'b0, 12'h600, 32'h0, 1'b1);
    apb(1'b1, 12'h51a, 32'hffff_ffff, 1'b1);
    for (int i = 0; i < 24; i++) begin
      if (i == 12) apb(1'b1, 12'h5c0, 32'h10, 1'b0);
      chk = i >= 12;
      r = $random(seed);
      rx(r[0] ? 4'h5 : r[7:4], r[1] ? 8'ha7 : r[15:8]);
    end
    t = 2'h0;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 12'h520, {23'h7fffff, k[0], 6'h3f, k[1:0]}, 1'b0);
      if (k != 3) t = k[1:0];
      apb(1'b0, 12'h520, {23'h0, k[0], 6'h0, t}, 1'b0);
      check("unit_select", {29'h0, timestamp_unit_select, trigger_unit_select}, {29'h0, k[0], t});
      unit_q.push_back({k[0], 2'h1 << k[0], 3'h1 << t});
      apb(k[0], k[1] ? 12'h5b0 : 12'h52c, 32'h0, 1'b0);
    end
    apb(1'b1, 12'h5c4, 32'h0007_0007, 1'b0);
    for (int u = 0; u < 3; u++) begin
      ev(3'h1 << u, 3'h0, 3'h0, 3'h7);
      check("irq", {31'h0, irq}, 32'h1);
      apb(1'b0, 12'h524, 32'h1 << u, 1'b0);
      apb(1'b1, 12'h524, 32'h1 << u, 1'b0);
      ev(3'h0, 3'h1 << u, 3'h0, 3'h0);
      apb(1'b0, 12'h524, 32'h0, 1'b0);
      check("irq", {31'h0, irq}, 32'h0);
      ev(3'h0, 3'h1 << u, 3'h0, 3'h7);
      apb(1'b0, 12'h524, 32'h1 << (16 + u), 1'b0);
      ev(3'h0, 3'h0, 3'h1 << u, 3'h7);
      apb(1'b0, 12'h524, 32'h0, 1'b0);
    end
    apb(1'b1, 12'h5c4, 32'h0, 1'b0);
    ev(3'h7, 3'h7, 3'h0, 3'h7);
    check("irq", {31'h0, irq}, 32'h0);
    apb(1'b1, 12'h5c8, 32'h0005_0002, 1'b0);
    apb(1'b0, 12'h524, 32'h0002_0005, 1'b0);
    apb(1'b1, 12'h5c4, 32'h0002_0000, 1'b0);
    @(posedge pclk);
    check("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, 12'h524, 32'h0002_0000, 1'b0);
    apb(1'b0, 12'h524, 32'h0000_0005, 1'b0);
    check("irq", {31'h0, irq}, 32'h0);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h518, 32'h200, 1'b0);
    apb(1'b0, 12'h520, 32'h0, 1'b0);
    apb(1'b0, 12'h524, 32'h0, 1'b0);
    check("irq", {31'h0, irq}, 32'h0);
    give_verdict();
  end
  // Hang guard
  initial begin
    #200000;
    errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
